/* verilog/hpag_pkg.sv */
package hpag_pkg;

   // Command opcodes seen by the guard.
   localparam logic [7:0] CMD_READ_NATIVE = 8'hf8;  // Read native maximum address.
   localparam logic [7:0] CMD_SET_MAX     = 8'hf9;  // Set maximum address.

   // Set-max sub-functions carried in the feature byte of a set-max command.
   localparam logic [7:0] SUB_SET_ADDR = 8'h00;  // Load a new maximum.
   localparam logic [7:0] SUB_SET_PWD  = 8'h01;  // Store the password.
   localparam logic [7:0] SUB_LOCK     = 8'h02;  // Enter the locked state.
   localparam logic [7:0] SUB_UNLOCK   = 8'h03;  // Leave the locked state.
   localparam logic [7:0] SUB_FREEZE   = 8'h04;  // Enter the frozen state.

   // Widths of addresses and passwords.
   localparam int LBA_W = 48;  // Logical block address width.
   localparam int PWD_W = 32;  // Password width.

   // Native maximum LBA after reset; default is a plain value.
   localparam logic [LBA_W-1:0] NATIVE_MAX_RST = 48'h0000_00c1_acff;

   // Identify word bit positions.
   localparam int IDW_SUPPORT_BIT = 8;  // Support bit, word 83.
   localparam int IDW_ENABLE_BIT  = 8;  // Enable bit, word 86.

   // AHB-Lite register byte offsets.
   localparam logic [7:0] REG_CMD      = 8'h00;  // Opcode, feature, volatile flag.
   localparam logic [7:0] REG_LBA_LO   = 8'h04;  // Argument LBA bits 31:0.
   localparam logic [7:0] REG_LBA_HI   = 8'h08;  // Argument LBA bits 47:32.
   localparam logic [7:0] REG_PWD      = 8'h0c;  // Argument password.
   localparam logic [7:0] REG_STATUS   = 8'h10;  // Error flag and protection state.
   localparam logic [7:0] REG_RES_LO   = 8'h14;  // Result LBA bits 31:0.
   localparam logic [7:0] REG_RES_HI   = 8'h18;  // Result LBA bits 47:32.
   localparam logic [7:0] REG_CUR_LO   = 8'h1c;  // Current maximum bits 31:0.
   localparam logic [7:0] REG_CUR_HI   = 8'h20;  // Current maximum bits 47:32.
   localparam logic [7:0] REG_IDENT    = 8'h24;  // Word 86 in 31:16, word 83 in 15:0.
   localparam logic [7:0] REG_NVMAX_LO = 8'h28;  // Nonvolatile maximum bits 31:0.
   localparam logic [7:0] REG_NVMAX_HI = 8'h2c;  // Nonvolatile maximum bits 47:32.

   // Command register field positions.
   localparam int CMD_OP_LSB   = 0;   // Opcode lowest bit.
   localparam int CMD_FEAT_LSB = 8;   // Feature lowest bit.
   localparam int CMD_VOL_BIT  = 16;  // Volatile option bit.

   // Protection states of the max-address security extension.
   typedef enum logic [1:0] {
      HPAG_NOPWD,
      HPAG_UNLOCKED,
      HPAG_LOCKED,
      HPAG_FROZEN
   } hpag_prot_t;

   // One media access request from the drive datapath.
   typedef struct packed {
      logic             valid;  // Request present.
      logic             write;  // Write access.
      logic [LBA_W-1:0] first;  // First LBA.
      logic [LBA_W-1:0] last;   // Last LBA.
   } hpag_media_req_t;

   // Verdict on a media access request.
   typedef struct packed {
      logic valid;  // Verdict present.
      logic grant;  // Access may proceed.
      logic abort;  // Access aborted with error.
   } hpag_media_rsp_t;

endpackage : hpag_pkg

/* verilog/hpag_guard.sv */
// Operation
// - Read native returns true native maximum LBA.
// - Set max updates current max and identify.
// - Volatile max lost at reset; nonvolatile kept.
// - Sectors above current maximum stay inaccessible.
// - Password kept across resets, lost at power-off.
// - Password separate from general security passwords.
// - Setting password enters unlocked state.
// - Lock disables max commands except unlock.
// - Unlock returns locked state to unlocked.
// - Freeze disables every max command until power-off.
// - Identify reports extension support and enable.
`timescale 1ns/1ns
module hpag_guard
   import hpag_pkg::*;
(
   input  wire logic                  CLK_SYS,       // System clock, 25 MHz.
   input  wire logic                  RSTN,          // Hard or soft reset, active low.
   input  wire logic                  POR_N,         // Power-on reset, active low.
   input  wire logic                  CE,            // Clock enable; low freezes state.
   input  wire logic                  HSEL,          // AHB-Lite slave select.
   input  wire logic [31:0]           HADDR,         // AHB-Lite address.
   input  wire logic [1:0]            HTRANS,        // AHB-Lite transfer type.
   input  wire logic                  HWRITE,        // AHB-Lite write flag.
   input  wire logic [2:0]            HSIZE,         // AHB-Lite transfer size.
   input  wire logic [31:0]           HWDATA,        // AHB-Lite write data.
   input  wire logic                  HREADY,        // AHB-Lite bus ready.
   output logic      [31:0]           HRDATA,        // AHB-Lite read data.
   output logic                       HREADYOUT,     // AHB-Lite slave ready.
   output logic                       HRESP,         // AHB-Lite response, always OKAY.
   input  wire hpag_media_req_t       MEDIA_REQ,     // Media access request.
   output hpag_media_rsp_t            MEDIA_RSP,     // Media access verdict.
   output logic      [LBA_W-1:0]      CUR_MAX        // Current maximum LBA.
);

   // Bus address phase capture.
   logic             ph_wr;        // Pending write data phase.
   logic [7:0]       ph_addr;      // Pending byte address.

   // Argument registers written by software.
   logic [31:0]      arg_cmd;      // Command word.
   logic [LBA_W-1:0] arg_lba;      // Argument LBA.
   logic [PWD_W-1:0] arg_pwd;      // Argument password.
   logic             cmd_go;       // One-cycle command launch.

   // Guard state.
   logic [LBA_W-1:0] native_max;   // True native maximum.
   // The nonvolatile cells start at the factory setting; no reset touches them.
   logic [LBA_W-1:0] nv_max = NATIVE_MAX_RST;  // Nonvolatile maximum, survives power cycles.
   logic [LBA_W-1:0] cur_max;      // Current maximum in force.
   logic [LBA_W-1:0] result;       // Result of the last command.
   logic [PWD_W-1:0] max_pwd;      // Max-address password, own storage only.
   hpag_prot_t       prot;         // Protection state.
   logic             cmd_err;      // Last command aborted.
   logic             hide_nv = 1'b0;  // Nonvolatile maximum lies below the native maximum.
   logic             vol_held;     // Volatile maximum in force since the last reset.

   // Decoded command fields.
   logic [7:0]       op;           // Opcode.
   logic [7:0]       feat;         // Feature sub-function.
   logic             vol;          // Volatile option.
   logic             set_addr_ok;  // Set max address may run.
   logic             max_cmds_off; // Max commands disabled by state.

   // Fields of the command word.
   assign op   = arg_cmd[CMD_OP_LSB +: 8];
   assign feat = arg_cmd[CMD_FEAT_LSB +: 8];
   assign vol  = arg_cmd[CMD_VOL_BIT];
   // Lock disables all but unlock; freeze disables everything.
   assign max_cmds_off = (prot == HPAG_LOCKED) || (prot == HPAG_FROZEN);
   // A new maximum may never exceed the native one.
   assign set_addr_ok  = !max_cmds_off && (arg_lba <= native_max);

   // Bus handshake: the slave is always ready and always answers OKAY.
   always_ff @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         // Reset drops any pending write and leaves the slave ready.
         ph_wr     <= 1'b0;
         ph_addr   <= 8'h00;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
      else if (CE)
      begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
         // A new address phase is only taken while the bus is ready.
         if (HREADY)
         begin
            // Capture a valid write address phase for the next cycle.
            ph_wr   <= HSEL && HTRANS[1] && HWRITE;
            ph_addr <= HADDR[7:0];
         end
      end
   end

   // Argument registers and command launch on a write to the command word.
   always_ff @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         // Reset clears the arguments and cancels a launch.
         arg_cmd <= 32'h0000_0000;
         arg_lba <= {LBA_W{1'b0}};
         arg_pwd <= {PWD_W{1'b0}};
         cmd_go  <= 1'b0;
      end
      else if (CE)
      begin
         // The launch strobe lasts exactly one enabled cycle.
         cmd_go <= 1'b0;
         if (ph_wr)
         begin
            case (ph_addr)
               REG_CMD:
               begin
                  // Writing the command word starts the command.
                  arg_cmd <= HWDATA;
                  cmd_go  <= 1'b1;
               end
               REG_LBA_LO: arg_lba[31:0]       <= HWDATA;
               REG_LBA_HI: arg_lba[LBA_W-1:32] <= HWDATA[LBA_W-33:0];
               REG_PWD:    arg_pwd             <= HWDATA;
               default:    ;  // Other offsets ignore writes.
            endcase
         end
      end
   end

   // Native maximum: a fixed property of the drive, loaded at power-on.
   always_ff @(posedge CLK_SYS)
   begin
      if (!POR_N)
      begin
         native_max <= NATIVE_MAX_RST;
      end
   end

   // Nonvolatile store: no reset clears it, so a maximum set with the
   // nonvolatile option and its hidden flag outlive power cycles.
   always_ff @(posedge CLK_SYS)
   begin
      if (CE && RSTN && POR_N && cmd_go && op == CMD_SET_MAX && feat == SUB_SET_ADDR
          && set_addr_ok && !vol)
      begin
         // Only a nonvolatile set reaches the store.
         nv_max  <= arg_lba;
         hide_nv <= (arg_lba < native_max);
      end
   end

   // Current maximum: reset restores the nonvolatile value, dropping volatile ones.
   always_ff @(posedge CLK_SYS)
   begin
      if (!RSTN || !POR_N)
      begin
         cur_max <= NATIVE_MAX_RST;  // Reloaded below once reset is released.
      end
      else if (CE)
      begin
         if (cmd_go && op == CMD_SET_MAX && feat == SUB_SET_ADDR && set_addr_ok)
         begin
            // An accepted set-max command takes effect at once.
            cur_max <= arg_lba;
         end
         else if (!cmd_go && cur_max != nv_max && !vol_held)
         begin
            // Otherwise fall back to the stored nonvolatile maximum.
            cur_max <= nv_max;
         end
      end
   end

   // Tracks that the current maximum came from a volatile set.
   always_ff @(posedge CLK_SYS)
   begin
      if (!RSTN || !POR_N)
      begin
         vol_held <= 1'b0;  // Volatile setting is discarded by any reset.
      end
      else if (CE && cmd_go && op == CMD_SET_MAX && feat == SUB_SET_ADDR && set_addr_ok)
      begin
         // Remember whether the last accepted maximum was volatile.
         vol_held <= vol;
      end
   end

   // Password and protection state: only power-on reset clears them.
   always_ff @(posedge CLK_SYS)
   begin
      if (!POR_N)
      begin
         // Power-on forgets the password; a hard reset leaves it alone.
         max_pwd <= {PWD_W{1'b0}};
         prot    <= HPAG_NOPWD;
      end
      else if (CE && cmd_go && op == CMD_SET_MAX)
      begin
         case (feat)
            SUB_SET_PWD:
            begin
               if (!max_cmds_off)
               begin
                  // Own storage, never shared with other passwords.
                  max_pwd <= arg_pwd;
                  prot    <= HPAG_UNLOCKED;
               end
            end
            SUB_LOCK:
            begin
               if (prot == HPAG_UNLOCKED)
               begin
                  // Locking needs a password to have been set.
                  prot <= HPAG_LOCKED;
               end
            end
            SUB_UNLOCK:
            begin
               if (prot == HPAG_LOCKED && arg_pwd == max_pwd)
               begin
                  // Unlock only with the matching password.
                  prot <= HPAG_UNLOCKED;
               end
            end
            SUB_FREEZE:
            begin
               if (!max_cmds_off && prot != HPAG_NOPWD)
               begin
                  // Freeze holds until the next power-on reset.
                  prot <= HPAG_FROZEN;
               end
            end
            default: ;  // Address loads are handled elsewhere.
         endcase
      end
   end

   // Command result and abort flag.
   always_ff @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         // Reset clears the result and the error flag.
         result  <= {LBA_W{1'b0}};
         cmd_err <= 1'b0;
      end
      else if (CE && cmd_go)
      begin
         cmd_err <= 1'b0;
         // Each command decides its own error outcome.
         case (op)
            CMD_READ_NATIVE:
            begin
               // The true native maximum, whatever the current setting.
               result <= native_max;
            end
            CMD_SET_MAX:
            begin
               case (feat)
                  SUB_SET_ADDR: cmd_err <= !set_addr_ok;
                  SUB_SET_PWD:  cmd_err <= max_cmds_off;
                  SUB_LOCK:     cmd_err <= (prot != HPAG_UNLOCKED);
                  SUB_UNLOCK:   cmd_err <= !(prot == HPAG_LOCKED && arg_pwd == max_pwd);
                  SUB_FREEZE:   cmd_err <= max_cmds_off || prot == HPAG_NOPWD;
                  default:      cmd_err <= 1'b1;
               endcase
            end
            default: cmd_err <= 1'b1;  // Unknown opcode is aborted.
         endcase
      end
   end

   // Media access screening against the current maximum.
   always_ff @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         // Reset withdraws any verdict.
         MEDIA_RSP <= '0;
      end
      else if (CE)
      begin
         // A verdict follows every request by one cycle.
         MEDIA_RSP.valid <= MEDIA_REQ.valid;
         MEDIA_RSP.grant <= MEDIA_REQ.valid && MEDIA_REQ.last <= cur_max
                            && MEDIA_REQ.first <= MEDIA_REQ.last;
         MEDIA_RSP.abort <= MEDIA_REQ.valid && !(MEDIA_REQ.last <= cur_max
                            && MEDIA_REQ.first <= MEDIA_REQ.last);
      end
   end

   // Registered copy of the current maximum for the identify capacity.
   always_ff @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         // Reset shows the native size until the reload arrives.
         CUR_MAX <= NATIVE_MAX_RST;
      end
      else if (CE)
      begin
         // Capacity follows the maximum in force.
         CUR_MAX <= cur_max;
      end
   end

   // Read data for the address phase being accepted.
   always_ff @(posedge CLK_SYS)
   begin
      if (!RSTN)
      begin
         // Reset clears the read data.
         HRDATA <= 32'h0000_0000;
      end
      else if (CE && HREADY && HSEL && HTRANS[1] && !HWRITE)
      begin
         // Decode the accepted address phase; data stands until the next read.
         case (HADDR[7:0])
            REG_CMD:      HRDATA <= arg_cmd;
            REG_LBA_LO:   HRDATA <= arg_lba[31:0];
            REG_LBA_HI:   HRDATA <= {16'h0000, arg_lba[LBA_W-1:32]};
            REG_STATUS:   HRDATA <= {28'h0000000, hide_nv, prot, cmd_err};
            REG_RES_LO:   HRDATA <= result[31:0];
            REG_RES_HI:   HRDATA <= {16'h0000, result[LBA_W-1:32]};
            REG_CUR_LO:   HRDATA <= cur_max[31:0];
            REG_CUR_HI:   HRDATA <= {16'h0000, cur_max[LBA_W-1:32]};
            REG_IDENT:    HRDATA <= {7'h00, prot != HPAG_NOPWD, 8'h00,
                                     7'h00, 1'b1, 8'h00};
            REG_NVMAX_LO: HRDATA <= nv_max[31:0];
            REG_NVMAX_HI: HRDATA <= {16'h0000, nv_max[LBA_W-1:32]};
            default:      HRDATA <= 32'h0000_0000;  // Password and unmapped read zero.
         endcase
      end
   end

endmodule : hpag_guard

/* verif/hpag_guard_assertions.sv */
`timescale 1ns/1ns
module hpag_guard_chk
   import hpag_pkg::*;
(
   input wire logic             CLK_SYS,    // System clock.
   input wire logic             RSTN,       // Hard reset, active low.
   input wire logic             POR_N,      // Power-on reset, active low.
   input wire logic             HSEL,       // Slave select.
   input wire logic [31:0]      HADDR,      // Bus address.
   input wire logic [1:0]       HTRANS,     // Transfer type.
   input wire logic             HWRITE,     // Write flag.
   input wire logic             HREADY,     // Bus ready.
   input wire logic [31:0]      HRDATA,     // Read data.
   input wire logic             HREADYOUT,  // Slave ready.
   input wire logic             HRESP,      // Slave response.
   input wire hpag_media_req_t  MEDIA_REQ,  // Media request.
   input wire hpag_media_rsp_t  MEDIA_RSP,  // Media verdict.
   input wire logic [LBA_W-1:0] CUR_MAX     // Current maximum.
);
   // A taken address phase, read or command write.
   wire logic take   = HSEL && HTRANS[1] && HREADY;
   wire logic rd_any = take && !HWRITE;
   wire logic cmd_wr = take && HWRITE && (HADDR[7:0] == REG_CMD);
   logic [3:0] since_cmd;  // Cycles since the last command write.
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN || !POR_N);
   // Counts cycles so that a change of the maximum can be traced to a command.
   always_ff @(posedge CLK_SYS)
   begin
      if (!RSTN || !POR_N || cmd_wr)
         since_cmd <= 4'h0;
      else if (since_cmd != 4'hf)
         since_cmd <= since_cmd + 4'h1;
   end
   // Address phase of an identify read.
   sequence s_rd_ident;
      rd_any && (HADDR[7:0] == REG_IDENT);
   endsequence
   // The verdict matches the range against the maximum in force at the request.
   sequence s_verdict;
      MEDIA_RSP.valid && (MEDIA_RSP.abort != MEDIA_RSP.grant) && (MEDIA_RSP.grant ==
         ($past(MEDIA_REQ.first) <= $past(MEDIA_REQ.last) && $past(MEDIA_REQ.last) <= CUR_MAX));
   endsequence
   chk_ready_high: assert property (HREADYOUT) else $error("slave ready dropped");
   chk_resp_okay: assert property (!HRESP) else $error("error response given");
   chk_rd_stand: assert property (!rd_any |=> $stable(HRDATA)) else $error("read data moved");
   chk_ident_bit: assert property (s_rd_ident |=> HRDATA[IDW_SUPPORT_BIT])
      else $error("support bit clear");
   chk_media_verdict: assert property (MEDIA_REQ.valid |=> s_verdict)
      else $error("wrong media verdict");
   chk_verdict_idle: assert property (!MEDIA_REQ.valid |=> !MEDIA_RSP.valid)
      else $error("verdict without request");
   chk_max_native: assert property (CUR_MAX <= NATIVE_MAX_RST)
      else $error("maximum above native");
   chk_max_cause: assert property ($changed(CUR_MAX) |-> since_cmd <= 4'h6)
      else $error("maximum moved without command");
endmodule : hpag_guard_chk
bind hpag_guard hpag_guard_chk u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .POR_N(POR_N),
   .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
   .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MEDIA_REQ(MEDIA_REQ),
   .MEDIA_RSP(MEDIA_RSP), .CUR_MAX(CUR_MAX));

/* verif/hpag_host_model.sv */
`timescale 1ns/1ns
module hpag_host_model
   import hpag_pkg::*;
(
   input  wire logic            clk,     // Bus clock.
   input  wire logic            hready,  // Bus ready.
   input  wire logic [31:0]     hrdata,  // Read data.
   input  wire hpag_media_rsp_t mrsp,    // Media verdict.
   output logic                 hsel,    // Slave select.
   output logic [31:0]          haddr,   // Address.
   output logic [1:0]           htrans,  // Transfer type.
   output logic                 hwrite,  // Write flag.
   output logic [2:0]           hsize,   // Always a word.
   output logic [31:0]          hwdata,  // Write data.
   output hpag_media_req_t      mreq     // Media request.
);
   // The host starts idle.
   initial
   begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
      mreq = '0;
   end
   // One single word transfer; called right after a rising edge.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      hsize  <= 3'b010;
      do @(posedge clk); while (!hready);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (!hready);
      q = hrdata;
   endtask : xfer
   // One media request; the verdict is read in the following cycle.
   task automatic access(input logic wr, input logic [47:0] f, l, output hpag_media_rsp_t r);
      mreq <= '{1'b1, wr, f, l};
      @(posedge clk);
      mreq.valid <= 1'b0;
      @(posedge clk);
      r = mrsp;
   endtask : access
endmodule : hpag_host_model

/* verif/hpag_guard_tb.sv */
`timescale 1ns/1ns
module hpag_guard_tb;
   import hpag_pkg::*;
   localparam logic [47:0] LOW = 48'h0000_00bb_85ff;  // Maximum that hides an area.
   logic            clk_sys = 1'b0;  // System clock.
   logic            rstn    = 1'b0;  // Hard reset.
   logic            por_n   = 1'b0;  // Power-on reset.
   logic            hsel, hwrite, hready, hresp;
   logic [1:0]      htrans;
   logic [2:0]      hsize;
   logic [31:0]     haddr, hwdata, hrdata;
   hpag_media_req_t mreq;
   hpag_media_rsp_t mrsp;
   logic [47:0]     cur_max;
   int              n_errors = 0;
   int              n_checks = 0;
   always #20 clk_sys = ~clk_sys;
   hpag_guard u_dut (.CLK_SYS(clk_sys), .RSTN(rstn), .POR_N(por_n), .CE(1'b1), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
      .MEDIA_REQ(mreq), .MEDIA_RSP(mrsp), .CUR_MAX(cur_max));
   hpag_host_model u_host (.clk(clk_sys), .hready(hready), .hrdata(hrdata), .mrsp(mrsp),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .mreq(mreq));
   // Compares one value and counts it.
   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Issues a command and waits until its status may be read.
   task automatic cmd(input logic [7:0] op, sub, input logic vol);
      logic [31:0] q;
      u_host.xfer(1'b1, REG_CMD, {15'h0, vol, sub, op}, q);
      repeat (3) @(posedge clk_sys);
   endtask : cmd
   task automatic setmax(input logic [47:0] v, input logic vol);
      logic [31:0] q;
      u_host.xfer(1'b1, REG_LBA_LO, v[31:0], q);
      u_host.xfer(1'b1, REG_LBA_HI, {16'h0, v[47:32]}, q);
      cmd(CMD_SET_MAX, SUB_SET_ADDR, vol);
   endtask : setmax
   task automatic rd48(input logic [7:0] a, output logic [47:0] v);
      logic [31:0] lo, hi;
      u_host.xfer(1'b0, a, 32'h0, lo);
      u_host.xfer(1'b0, a + 8'h04, 32'h0, hi);
      v = {hi[15:0], lo};
   endtask : rd48
   // Status holds hidden flag, state and error in bits 3:0.
   task automatic st(input logic [3:0] exp);
      logic [31:0] q;
      u_host.xfer(1'b0, REG_STATUS, 32'h0, q);
      chk("status", {44'h0, exp}, {44'h0, q[3:0]});
   endtask : st
   task automatic media(input logic [47:0] f, l, input logic wr, g);
      hpag_media_rsp_t r;
      u_host.access(wr, f, l, r);
      chk("media verdict", {45'h0, 1'b1, g, ~g}, {45'h0, r});
   endtask : media
   // Hard reset alone, or with power-on reset.
   task automatic pwr(input logic por);
      rstn <= 1'b0;
      por_n <= ~por;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      por_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask : pwr
   task automatic ident(input logic [31:0] exp);
      logic [31:0] q;
      u_host.xfer(1'b0, REG_IDENT, 32'h0, q);
      chk("identify", {16'h0, exp}, {16'h0, q & 32'h0100_0100});
   endtask : ident
   // Prepares a hidden area and probes its edges.
   task automatic t_area;
      logic [47:0] v;
      cmd(CMD_READ_NATIVE, SUB_SET_ADDR, 1'b0);
      rd48(REG_RES_LO, v);
      chk("native", NATIVE_MAX_RST, v);
      setmax(NATIVE_MAX_RST, 1'b0);
      media(NATIVE_MAX_RST, NATIVE_MAX_RST, 1'b1, 1'b1);
      setmax(LOW, 1'b0);
      chk("current max", LOW, cur_max);
      rd48(REG_CUR_LO, v);
      chk("current reg", LOW, v);
      st(4'h8);
      media(LOW, LOW, 1'b1, 1'b1);
      media(LOW, LOW + 48'h1, 1'b0, 1'b0);
      media(LOW + 48'h1, LOW + 48'h1, 1'b1, 1'b0);
      setmax(NATIVE_MAX_RST + 48'h1, 1'b0);
      st(4'h9);
      chk("max kept", LOW, cur_max);
      cmd(CMD_READ_NATIVE, SUB_SET_ADDR, 1'b0);
      rd48(REG_RES_LO, v);
      chk("native again", NATIVE_MAX_RST, v);
   endtask : t_area
   // Volatile opening of the area and reset behaviour.
   task automatic t_volatile;
      logic [47:0] v;
      setmax(NATIVE_MAX_RST, 1'b1);
      chk("volatile max", NATIVE_MAX_RST, cur_max);
      media(NATIVE_MAX_RST, NATIVE_MAX_RST, 1'b0, 1'b1);
      pwr(1'b0);
      chk("after reset", LOW, cur_max);
      pwr(1'b1);
      chk("after power", LOW, cur_max);
      rd48(REG_NVMAX_LO, v);
      chk("stored max", LOW, v);
   endtask : t_volatile
   // Password, lock, unlock and freeze.
   task automatic t_lock;
      logic [31:0] q;
      u_host.xfer(1'b1, 8'h40, 32'hffff_ffff, q);
      u_host.xfer(1'b0, 8'h40, 32'h0, q);
      chk("unmapped", 48'h0, {16'h0, q});
      ident(32'h0000_0100);
      u_host.xfer(1'b1, REG_PWD, 32'h5a3c_96e1, q);
      cmd(CMD_SET_MAX, SUB_SET_PWD, 1'b0);
      st(4'ha);
      ident(32'h0100_0100);
      pwr(1'b0);
      st(4'ha);
      cmd(CMD_SET_MAX, SUB_LOCK, 1'b0);
      st(4'hc);
      setmax(NATIVE_MAX_RST, 1'b0);
      st(4'hd);
      chk("locked max", LOW, cur_max);
      u_host.xfer(1'b1, REG_PWD, 32'h0, q);
      cmd(CMD_SET_MAX, SUB_UNLOCK, 1'b0);
      st(4'hd);
      u_host.xfer(1'b1, REG_PWD, 32'h5a3c_96e1, q);
      cmd(CMD_SET_MAX, SUB_UNLOCK, 1'b0);
      st(4'ha);
      cmd(CMD_SET_MAX, SUB_FREEZE, 1'b0);
      st(4'he);
      cmd(CMD_SET_MAX, SUB_UNLOCK, 1'b0);
      st(4'hf);
      setmax(NATIVE_MAX_RST, 1'b1);
      st(4'hf);
      chk("frozen max", LOW, cur_max);
      pwr(1'b1);
      st(4'h8);
   endtask : t_lock
   task automatic summarize;
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   // Cuts a hang short.
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      summarize;
   end
   // Main sequence after a power-on reset of 12 cycles.
   initial
   begin
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      por_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      t_area;
      t_volatile;
      t_lock;
      summarize;
   end
endmodule : hpag_guard_tb
